/* File: sfpos_sequencer.sv */
/*
  Wake-up sequencer: detects startup causes, drives the supply-on
  indicator for the programmed wait, samples battery inhibit, then
  releases reset and starts cold reset, or flags inhibit and shuts down.
  Assumes an always-on 10 MHz clock and rstn as the RTC-domain reset.
*/
// Behaviour
// - Eleven wake causes wake from sleep
// - Low battery inhibit blocks activation
// - Wait count programmable, default 343.78 ms
// - Switch rise: indicator on, sample, off
// - Inhibit high: release peripherals, cold reset
// - Inhibit low: set flag, back to shutdown
// - Switch wake never sets switch flag
// - Pin wakes only when enabled
// - Reset clears enables except pin three
// - Pin wake sets its flag always
// - Pin changes ignored while switch active
// - Carrier fall starts activation
// - Carrier status bit shows live level
// - Carrier changes masked while indicator on
// - Carrier fall held during switch, acted on after release if still low
// - Alarm starts activation
// - Alarm held during switch, delivered after
// - Wake at sleep entry skips indicator
// - Inhibit flag bit 8, write-one clear
// - Carrier level bit 10
`timescale 1ns/1ps
`default_nettype none
module sfpos_sequencer
  import sfpos_pkg::*;
#(
  parameter logic [WAIT_W-1:0] WAIT_RESET = WAIT_DEFAULT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic power_switch,
  input wire logic [N_PIN-1:0] wake_pin,
  input wire logic carrier_detect_n,
  input wire logic alarm,
  input wire logic battery_inhibit_n,
  input wire logic reset_switch_n,
  input wire logic sleep_request,
  input wire logic shutdown_request,
  input wire logic [N_PIN-1:0] pin_enable_wdata,
  input wire logic pin_enable_we,
  input wire logic [WAIT_W-1:0] wake_wait_count_wdata,
  input wire logic wake_wait_count_we,
  input wire logic [15:0] pm_status_clear,
  input wire logic [N_PIN-1:0] pin_flag_clear,
  output logic supply_on_indicator,
  output logic main_supply_enable,
  output logic peripheral_reset_n,
  output logic cold_reset_start,
  output logic [N_PIN-1:0] pin_enable,
  output logic [WAIT_W-1:0] wake_wait_count_reg,
  output sfpos_status_s status,
  output logic [15:0] pm_status_reg,
  output logic [2:0] seq_state
);
  sfpos_state_e state;
  logic sw_lvl;
  logic sw_prev;
  logic [N_PIN-1:0] pin_lvl;
  logic [N_PIN-1:0] pin_prev;
  logic cd_lvl;
  logic cd_ref;
  logic al_lvl;
  logic al_pending;
  logic al_prev;
  logic rst_lvl;
  logic batt_lvl;
  logic after_reset;
  logic sleeping;
  sfpos_cause_s cause;
  logic [N_PIN-1:0] pin_hit;
  logic any_wake;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic [SAMPLE_DELAY_CYC-1:0] sample_cnt;
  logic batt_flag;
  logic sw_flag;
  logic [N_PIN-1:0] pin_flag;

  // Wake inputs pass through the always-on synchronisers
  sfpos_sync #(.INIT(1'b0)) u_sw (.clock(clock), .rstn(rstn), .pin(power_switch),
    .level(sw_lvl));
  sfpos_sync #(.INIT(1'b1)) u_cd (.clock(clock), .rstn(rstn), .pin(carrier_detect_n),
    .level(cd_lvl));
  sfpos_sync #(.INIT(1'b0)) u_al (.clock(clock), .rstn(rstn), .pin(alarm),
    .level(al_lvl));
  sfpos_sync #(.INIT(1'b1)) u_bt (.clock(clock), .rstn(rstn), .pin(battery_inhibit_n),
    .level(batt_lvl));
  sfpos_sync #(.INIT(1'b1)) u_rs (.clock(clock), .rstn(rstn), .pin(reset_switch_n),
    .level(rst_lvl));

  genvar gi;
  generate
    for (gi = 0; gi < N_PIN; gi++) begin : g_pin
      sfpos_sync #(.INIT(1'b1)) u_pin (.clock(clock), .rstn(rstn), .pin(wake_pin[gi]),
        .level(pin_lvl[gi]));
    end
  endgenerate

  sfpos_wait #(.W(WAIT_W)) u_wait (
    .clock(clock),
    .rstn(rstn),
    .start(timer_start),
    .count(wake_wait_count_reg),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Edge history
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_prev <= 1'b0;
      pin_prev <= '1;
      al_prev <= 1'b0;
    end else begin
      sw_prev <= sw_lvl;
      pin_prev <= pin_lvl;
      al_prev <= al_lvl;
    end
  end

  // Carrier reference only follows outside indicator and switch windows
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cd_ref <= 1'b1;
    end else if (!supply_on_indicator && !sw_lvl) begin
      cd_ref <= cd_lvl;
    end
  end

  // Alarm held while switch active
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      al_pending <= 1'b0;
    end else if (al_lvl && !al_prev && sw_lvl) begin
      al_pending <= 1'b1;
    end else if (!sw_lvl) begin
      al_pending <= 1'b0;
    end
  end

  always_comb begin
    cause.switch_rise = sw_lvl && !sw_prev;
    // Pin 3 after reset wakes on falling edge only
    for (int i = 0; i < N_PIN; i++) begin
      if (after_reset && i == PIN3_IDX) begin
        cause.pin_edge[i] = !pin_lvl[i] && pin_prev[i] && !sw_lvl;
      end else begin
        cause.pin_edge[i] = (pin_lvl[i] != pin_prev[i]) && !sw_lvl;
      end
    end
    cause.carrier_fall = !cd_lvl && cd_ref && !supply_on_indicator && !sw_lvl;
    // Alarm acts on its rising edge so a held level cannot re-trigger
    cause.alarm = !sw_lvl && ((al_lvl && !al_prev) || al_pending);
    pin_hit = cause.pin_edge & pin_enable;
    any_wake = cause.switch_rise || (|pin_hit) || cause.carrier_fall || cause.alarm;
  end

  assign sleeping = (state == SFPOS_OFF) || (state == SFPOS_SLEEP);
  assign timer_start = sleeping && any_wake && (state == SFPOS_OFF);

  // Sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= SFPOS_OFF;
      sample_cnt <= '0;
    end else begin
      unique case (state)
        SFPOS_OFF: begin
          if (any_wake) begin
            state <= SFPOS_WAIT;
          end
        end
        SFPOS_WAIT: begin
          if (timer_done) begin
            state <= SFPOS_SAMPLE;
            sample_cnt <= '0;
          end
        end
        SFPOS_SAMPLE: begin
          sample_cnt <= sample_cnt + 1'b1;
          if (&sample_cnt) begin
            state <= batt_lvl ? SFPOS_RUN : SFPOS_OFF;
          end
        end
        SFPOS_RUN: begin
          if (shutdown_request) begin
            state <= SFPOS_OFF;
          end else if (sleep_request) begin
            state <= SFPOS_SLEEP;
          end
        end
        SFPOS_SLEEP: begin
          // Wake coinciding with sleep entry returns without indicator
          if (any_wake || !rst_lvl) begin
            state <= SFPOS_RUN;
          end
        end
      endcase
    end
  end

  // Indicator active through wait and sample
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      supply_on_indicator <= 1'b0;
    end else begin
      supply_on_indicator <= (state == SFPOS_WAIT) || (state == SFPOS_SAMPLE && !(&sample_cnt))
        || timer_start;
    end
  end

  // Main supply drops when sleeping, briefly even on direct re-wake
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      main_supply_enable <= 1'b0;
    end else begin
      main_supply_enable <= !sleeping;
    end
  end

  // Peripheral release then cold reset start
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      peripheral_reset_n <= 1'b0;
      cold_reset_start <= 1'b0;
    end else begin
      cold_reset_start <= 1'b0;
      if (state == SFPOS_SAMPLE && (&sample_cnt) && batt_lvl) begin
        peripheral_reset_n <= 1'b1;
      end else if (state == SFPOS_RUN && !peripheral_reset_n) begin
        peripheral_reset_n <= 1'b1;
      end else if (state == SFPOS_OFF) begin
        peripheral_reset_n <= 1'b0;
      end
      if (state == SFPOS_RUN && $past(state) != SFPOS_RUN) begin
        cold_reset_start <= 1'b1;
      end
    end
  end

  // Pin enables: reset leaves only pin three
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_enable <= PIN_EN_RESET;
      after_reset <= 1'b1;
    end else if (pin_enable_we) begin
      pin_enable <= pin_enable_wdata;
      after_reset <= 1'b0;
    end
  end

  // Wait count register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wake_wait_count_reg <= WAIT_RESET;
    end else if (wake_wait_count_we) begin
      wake_wait_count_reg <= wake_wait_count_wdata;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      batt_flag <= 1'b0;
      sw_flag <= 1'b0;
      pin_flag <= '0;
    end else begin
      if (state == SFPOS_SAMPLE && (&sample_cnt) && !batt_lvl) begin
        batt_flag <= 1'b1;
      end else if (pm_status_clear[ST_BATT_BIT]) begin
        batt_flag <= 1'b0;
      end
      // Switch wakes never touch this flag
      if (pm_status_clear[ST_SWITCH_BIT]) begin
        sw_flag <= 1'b0;
      end
      pin_flag <= (pin_flag & ~pin_flag_clear) | (sleeping ? pin_hit : '0);
    end
  end

  assign status.carrier_pin_level = cd_lvl;
  assign status.battery_inhibit_flag = batt_flag;
  assign status.switch_wake_flag = sw_flag;
  assign status.pin_wake_flag = pin_flag;
  assign seq_state = state;

  always_comb begin
    pm_status_reg = '0;
    pm_status_reg[ST_BATT_BIT] = batt_flag;
    pm_status_reg[ST_CARRIER_BIT] = cd_lvl;
    pm_status_reg[ST_SWITCH_BIT] = sw_flag;
  end
endmodule
`default_nettype wire

/* File: sfpos_pkg.sv */
/*
  Package for the wake-up sequencer: cause indices, timing constants,
  status bit positions and the state enumeration.
  Assumes a 10 MHz always-on clock.
*/
package sfpos_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int N_PIN = 8;
  localparam int WAIT_W = 24;
  // 343.78 ms default wait
  localparam real WAIT_DEFAULT_MS = 343.78;
  localparam logic [23:0] WAIT_DEFAULT_CYC = 24'(int'(WAIT_DEFAULT_MS * CLK_HZ / 1000.0));
  localparam int SAMPLE_DELAY_CYC = 2;
  localparam int ST_BATT_BIT = 8;
  localparam int ST_CARRIER_BIT = 10;
  localparam int ST_SWITCH_BIT = 0;
  localparam int PIN3_IDX = 3;
  localparam logic [7:0] PIN_EN_RESET = 8'h08;

  typedef enum logic [2:0] {
    SFPOS_OFF,
    SFPOS_WAIT,
    SFPOS_SAMPLE,
    SFPOS_RUN,
    SFPOS_SLEEP
  } sfpos_state_e;

  typedef struct packed {
    logic switch_rise;
    logic [7:0] pin_edge;
    logic carrier_fall;
    logic alarm;
  } sfpos_cause_s;

  typedef struct packed {
    logic carrier_pin_level;
    logic battery_inhibit_flag;
    logic switch_wake_flag;
    logic [7:0] pin_wake_flag;
  } sfpos_status_s;
endpackage

/* File: sfpos_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one pin.
  Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sfpos_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      level <= INIT;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule
`default_nettype wire

/* File: sfpos_wait.sv */
/*
  Supply-on wait timer: loads a count on start, pulses done at zero.
  Assumes start only while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module sfpos_wait #(
  parameter int W = 24
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);
  logic [W-1:0] remain;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= (count == '0) ? W'(1) : count;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain == W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain <= remain - W'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: sfpos_checker.sv */
/* Assertions on the wake-up sequencer ports.
   Bound to sfpos_sequencer below; WAIT_RESET is handed on. */
`timescale 1ns/1ps
`default_nettype none
module sfpos_checker
  import sfpos_pkg::*;
#(
  parameter logic [WAIT_W-1:0] WAIT_RESET = WAIT_DEFAULT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic carrier_detect_n,
  input wire logic supply_on_indicator,
  input wire logic peripheral_reset_n,
  input wire logic cold_reset_start,
  input wire logic [N_PIN-1:0] pin_enable,
  input wire logic [WAIT_W-1:0] wake_wait_count_reg,
  input wire sfpos_status_s status,
  input wire logic [15:0] pm_status_reg,
  input wire logic [2:0] seq_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [WAIT_W:0] on_cnt;
  // Cycles with the indicator high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) on_cnt <= '0;
    else if (supply_on_indicator) on_cnt <= on_cnt + 1'b1;
    else on_cnt <= '0;
  end
  sequence s_on_end;
    $fell(supply_on_indicator);
  endsequence
  sequence s_run_end;
    s_on_end ##0 seq_state == 3'd3;
  endsequence
  sequence s_off_end;
    s_on_end ##0 seq_state == 3'd0;
  endsequence
  chk_reset_values: assert property ($rose(rstn) |->
    pin_enable == PIN_EN_RESET && wake_wait_count_reg == WAIT_RESET) else $error("reset values");
  chk_on_length: assert property (s_on_end |-> on_cnt >= wake_wait_count_reg
    && on_cnt <= wake_wait_count_reg + 8) else $error("indicator length");
  chk_on_from_off: assert property ($rose(supply_on_indicator) |->
    $past(seq_state) inside {3'd0, 3'd4}) else $error("indicator outside idle");
  chk_run_cold: assert property (s_run_end |-> ##[0:2] cold_reset_start)
    else $error("no cold reset");
  chk_cold_release: assert property (cold_reset_start |-> peripheral_reset_n ##1
    !cold_reset_start) else $error("cold reset pulse");
  chk_inhibit_flag: assert property (s_off_end |-> ##[0:2]
    pm_status_reg[ST_BATT_BIT]) else $error("inhibit flag");
  chk_flag_mirror: assert property (pm_status_reg[ST_BATT_BIT] ==
    status.battery_inhibit_flag && pm_status_reg[ST_CARRIER_BIT] == status.carrier_pin_level)
    else $error("status mirror");
  chk_switch_flag: assert property (!status.switch_wake_flag) else $error("switch flag");
  chk_carrier_live: assert property ($stable(carrier_detect_n)[*8] |->
    pm_status_reg[ST_CARRIER_BIT] == carrier_detect_n) else $error("carrier level");
endmodule
bind sfpos_sequencer sfpos_checker #(.WAIT_RESET(WAIT_RESET)) i_sfpos_checker (.clock, .rstn,
  .carrier_detect_n, .supply_on_indicator, .peripheral_reset_n, .cold_reset_start,
  .pin_enable, .wake_wait_count_reg, .status, .pm_status_reg, .seq_state);
`default_nettype wire

/* File: sfpos_supply_model.sv */
/* External supply and battery monitor model.
   Assumes the indicator comes from the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module sfpos_supply_model (
  input wire logic clock,
  input wire logic supply_on_indicator,
  input wire logic batt_good,
  input wire logic slow,
  output logic battery_inhibit_n
);
  logic [3:0] ramp;
  always_ff @(posedge clock) begin
    if (!supply_on_indicator) ramp <= '0;
    else if (ramp != 4'hF) ramp <= ramp + 4'h1;
  end
  // Slow supply reads low until the ramp reaches four
  assign battery_inhibit_n = batt_good && !(slow && ramp < 4'h4);
endmodule
`default_nettype wire

/* File: sfpos_sequencer_tb.sv */
/* Self-checking bench for the wake-up sequencer.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module sfpos_sequencer_tb;
  import sfpos_pkg::*;
  localparam logic [WAIT_W-1:0] WRST = 24'h000014;
  logic clock = 1'b0, rstn = 1'b0, power_switch = 1'b0, carrier_detect_n = 1'b1;
  logic alarm = 1'b0, reset_switch_n = 1'b1, sleep_request = 1'b0, shutdown_request = 1'b0;
  logic [N_PIN-1:0] wake_pin = 8'hFF, pin_enable_wdata = 8'h00, pin_flag_clear = 8'h00;
  logic pin_enable_we = 1'b0, wake_wait_count_we = 1'b0, batt_good = 1'b1, slow = 1'b0;
  logic [WAIT_W-1:0] wake_wait_count_wdata = 24'h000000;
  logic [15:0] pm_status_clear = 16'h0000;
  logic supply_on_indicator, main_supply_enable, peripheral_reset_n, cold_reset_start;
  logic battery_inhibit_n;
  logic [N_PIN-1:0] pin_enable;
  logic [WAIT_W-1:0] wake_wait_count_reg;
  sfpos_status_s status;
  logic [15:0] pm_status_reg;
  logic [2:0] seq_state;
  int n_mismatch = 0, check_count = 0, cycles = 0, seed = 15462;
  sfpos_sequencer #(.WAIT_RESET(WRST)) i_sfpos_sequencer (.clock, .rstn, .power_switch,
    .wake_pin, .carrier_detect_n, .alarm, .battery_inhibit_n, .reset_switch_n, .sleep_request,
    .shutdown_request, .pin_enable_wdata, .pin_enable_we, .wake_wait_count_wdata,
    .wake_wait_count_we, .pm_status_clear, .pin_flag_clear, .supply_on_indicator,
    .main_supply_enable, .peripheral_reset_n, .cold_reset_start, .pin_enable,
    .wake_wait_count_reg, .status, .pm_status_reg, .seq_state);
  sfpos_supply_model i_sfpos_supply_model (.clock, .supply_on_indicator, .batt_good, .slow,
    .battery_inhibit_n);
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_vec(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cause 0 switch, 1..8 pins, 9 carrier, 10 alarm
  task automatic wake(input int c, input logic ok, input logic exp_on, input logic rel);
    int k;
    batt_good = ok;
    slow = 1'($random(seed));
    if (c == 0) power_switch = 1'b1;
    else if (c < 9) wake_pin[c-1] = ~wake_pin[c-1];
    else if (c == 9) carrier_detect_n = 1'b0;
    else alarm = 1'b1;
    k = 0;
    while (supply_on_indicator !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    check_bit(supply_on_indicator, exp_on);
    check_bit(pm_status_reg[ST_CARRIER_BIT], c != 9);
    k = 0;
    while (supply_on_indicator === 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    if (exp_on) check_bit(k >= wake_wait_count_reg && k <= wake_wait_count_reg + 8, 1'b1);
    if (rel) begin
      power_switch = 1'b0;
      carrier_detect_n = 1'b1;
      alarm = 1'b0;
    end
    tick(3);
    if (exp_on) begin
      check_vec(24'(seq_state), ok ? 24'h3 : 24'h0);
      check_bit(peripheral_reset_n, ok);
      check_bit(pm_status_reg[ST_BATT_BIT], !ok);
    end
    if (c > 0 && c < 9) check_bit(status.pin_wake_flag[c-1], exp_on);
    check_bit(status.switch_wake_flag, 1'b0);
    pm_status_clear = 16'h0100;
    pin_flag_clear = 8'hFF;
    shutdown_request = 1'b1;
    tick(1);
    pm_status_clear = 16'h0000;
    pin_flag_clear = 8'h00;
    k = 0;
    while (seq_state !== 3'd0 && k < 50) begin
      tick(1);
      k++;
    end
    shutdown_request = 1'b0;
    tick(2);
    check_bit(pm_status_reg[ST_BATT_BIT], 1'b0);
    $display("test cause %0d done", c);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    #10;
    rstn = 1'b1;
    tick(6);
    check_vec(wake_wait_count_reg, WRST);
    check_vec(24'(pin_enable), 24'(PIN_EN_RESET));
    check_vec(24'(pm_status_reg), 24'h000400);
    wake(1, 1'b1, 1'b0, 1'b1);
    wake(4, 1'b1, 1'b1, 1'b1);
    pin_enable_wdata = 8'hFF;
    pin_enable_we = 1'b1;
    wake_wait_count_wdata = 24'h00000A + 24'($random(seed) & 31);
    wake_wait_count_we = 1'b1;
    tick(1);
    pin_enable_we = 1'b0;
    wake_wait_count_we = 1'b0;
    tick(1);
    check_vec(24'(pin_enable), 24'h0000FF);
    check_vec(wake_wait_count_reg, wake_wait_count_wdata);
    for (int i = 0; i < 22; i++) wake(i % 11, i < 11, 1'b1, 1'b1);
    wake(0, 1'b0, 1'b1, 1'b0);
    wake_pin[0] = ~wake_pin[0];
    carrier_detect_n = 1'b0;
    alarm = 1'b1;
    tick(30);
    check_bit(supply_on_indicator, 1'b0);
    wake_pin[0] = ~wake_pin[0];
    carrier_detect_n = 1'b1;
    tick(10);
    power_switch = 1'b0;
    wake(10, 1'b1, 1'b1, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
